// >>> gig_autoneg_nextpage_ctrl_regs.sv
`timescale 1ns/1ps
`include "gig_autoneg_consts.svh"

module gig_autoneg_nextpage_ctrl_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_page,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic [3:0] negotiation_strap_pattern,
  input wire logic soft_reset,
  input wire logic negotiation_restart,
  input wire logic power_down,
  input wire logic copper_link_up,
  input wire logic fiber_link_up,
  input wire logic copper_np_valid,
  input wire logic [15:0] copper_np_word,
  input wire logic fiber_np_valid,
  input wire logic [15:0] fiber_np_word,
  output gig_autoneg_pkg::test_mode_e test_mode,
  output logic tx_clk_from_rx,
  output logic manual_ms,
  output logic force_master,
  output logic prefer_master,
  output logic adv_full,
  output logic adv_half
);
  import gig_autoneg_pkg::*;

  state_s cur;
  state_s nxt;

  // Register bus decode.
  logic page_copper;
  logic page_fiber;
  logic addr_next_page;
  logic addr_control;
  logic wr_ctrl;
  logic rd_copper;
  logic rd_fiber;
  logic rd_ctrl;

  // Link and power event detection.
  logic copper_drop;
  logic fiber_drop;
  logic power_up;
  logic apply_pending;

  // Strap defaults and the deferred control field.
  logic strap_stable;
  logic default_manual;
  logic default_value;
  logic default_port;
  logic default_full;
  logic default_half;
  logic [4:0] strap_defaults;
  logic [4:0] written_ctrl;
  logic [2:0] written_test;
  logic [4:0] next_pending;
  logic [4:0] next_active;
  logic [2:0] next_test_code;
  logic [3:0] next_strap_held;

  // Received next page updates.
  logic copper_clear;
  logic fiber_clear;
  logic copper_load;
  logic fiber_load;
  logic [15:0] next_np_copper;
  logic [15:0] next_np_fiber;

  // Active control bits in register order.
  logic act_manual;
  logic act_value;
  logic act_port;
  logic act_full;
  logic act_half;

  // Test mode decode and the effective role outputs.
  test_mode_e decoded_mode;
  logic jitter_mode;
  logic eff_manual;
  logic eff_value;
  logic eff_port;
  logic eff_full;
  logic eff_half;
  logic [15:0] control_readback;
  logic [15:0] next_rdata;

  // Page 1 register 9 is not mapped: writes there are dropped and reads return zero.
  always_comb begin
    page_copper = reg_page == `PAGE_COPPER;
    page_fiber = reg_page == `PAGE_FIBER;
    addr_next_page = reg_addr == `REG_PARTNER_NEXT_PAGE;
    addr_control = reg_addr == `REG_GIGABIT_CONTROL;
    wr_ctrl = reg_write && page_copper && addr_control;
    rd_copper = reg_read && page_copper && addr_next_page;
    rd_fiber = reg_read && page_fiber && addr_next_page;
    rd_ctrl = reg_read && page_copper && addr_control;
  end

  // Falling link and power-down levels are the events; the previous levels sit in the state.
  // Only the copper link loss applies deferred control writes; a fiber loss clears its own copy.
  always_comb begin
    copper_drop = cur.copper_link_prev && !copper_link_up;
    fiber_drop = cur.fiber_link_prev && !fiber_link_up;
    // Leaving power-down is the falling edge of the power-down level.
    power_up = cur.power_down_prev && !power_down;
    apply_pending = soft_reset
      || negotiation_restart
      || power_up
      || copper_drop;
  end

  always_comb begin
    default_manual = !cur.strap_held[`STRAP_MANUAL_BIT];
    default_value = !cur.strap_held[`STRAP_ROLE_BIT];
    default_port = !cur.strap_held[`STRAP_ROLE_BIT];
    default_full = cur.strap_held[`STRAP_FULL_BIT];
    default_half = cur.strap_held[`STRAP_HALF_BIT];
    // Default order is manual, value, port, full, half (bits 12..8).
    strap_defaults = {
      default_manual,
      default_value,
      default_port,
      default_full,
      default_half
    };
  end

  // A strap level counts only once two successive samples agree, so a slow edge never gives a mixed pattern.
  always_comb begin
    strap_stable = cur.strap_s2 == cur.strap_s3;
    next_strap_held = cur.strap_held;
    if (strap_stable) begin
      next_strap_held = cur.strap_s3;
    end
  end

  // Write data fields of the control register.
  always_comb begin
    written_test = reg_wdata[`CTL_TEST_MSB:`CTL_TEST_LSB];
    written_ctrl = reg_wdata[`CTL_MANUAL_BIT:`CTL_HALF_BIT];
  end

  // A loss of link or a software reset outranks a page arriving in the same cycle.
  always_comb begin
    copper_clear = copper_drop || soft_reset;
    fiber_clear = fiber_drop || soft_reset;
    copper_load = copper_np_valid && !copper_clear;
    fiber_load = fiber_np_valid && !fiber_clear;
  end

  // Clearing wins over a page in the same cycle, so a stale page never survives a drop.
  always_comb begin
    next_np_copper = cur.np_copper;
    if (sys_rst) begin
      next_np_copper = `NP_RESET;
    end else if (cur.defaults_loaded) begin
      if (copper_clear) begin
        next_np_copper = `NP_RESET;
      end else if (copper_load) begin
        next_np_copper = copper_np_word;
      end
    end
  end

  always_comb begin
    next_np_fiber = cur.np_fiber;
    if (sys_rst) begin
      next_np_fiber = `NP_RESET;
    end else if (cur.defaults_loaded) begin
      if (fiber_clear) begin
        next_np_fiber = `NP_RESET;
      end else if (fiber_load) begin
        next_np_fiber = fiber_np_word;
      end
    end
  end

  // Bits 12:8 wait in the pending copy until an apply event; read-back shows the pending copy.
  always_comb begin
    next_pending = cur.pending;
    next_active = cur.active;
    if (sys_rst) begin
      next_pending = 5'h00;
      next_active = 5'h00;
    end else if (!cur.defaults_loaded) begin
      next_pending = strap_defaults;
      next_active = strap_defaults;
    end else begin
      if (wr_ctrl) begin
        next_pending = written_ctrl;
      end
      // A write in the same cycle as an apply event is applied at once.
      if (apply_pending) begin
        next_active = next_pending;
      end
    end
  end

  // A restart outranks a test mode write in the same cycle; software reset keeps the code.
  always_comb begin
    next_test_code = cur.test_code;
    if (sys_rst) begin
      next_test_code = `CTL_TEST_RESET;
    end else if (cur.defaults_loaded) begin
      if (wr_ctrl) begin
        next_test_code = written_test;
      end
      if (negotiation_restart) begin
        next_test_code = `CTL_TEST_RESET;
      end
    end
  end

  // Codes 5 to 7 decode to the reserved mode and select no test.
  always_comb begin
    case (next_test_code)
      3'h0: decoded_mode = TM_NORMAL;
      3'h1: decoded_mode = TM_WAVEFORM;
      3'h2: decoded_mode = TM_JITTER_MASTER;
      3'h3: decoded_mode = TM_JITTER_SLAVE;
      3'h4: decoded_mode = TM_DISTORTION;
      default: decoded_mode = TM_RESERVED;
    endcase
    jitter_mode = decoded_mode == TM_JITTER_MASTER || decoded_mode == TM_JITTER_SLAVE;
  end

  always_comb begin
    act_manual = next_active[4];
    act_value = next_active[3];
    act_port = next_active[2];
    act_full = next_active[1];
    act_half = next_active[0];
  end

  // The role value only counts under manual configuration, the port type only without it.
  always_comb begin
    eff_manual = act_manual;
    eff_value = 1'b0;
    eff_port = 1'b0;
    if (act_manual) begin
      eff_value = act_value;
    end else begin
      eff_port = act_port;
    end
    eff_full = act_full;
    eff_half = act_half;
  end

  // Reserved bits 7:0 read as zero so that a read-modify-write keeps them zero.
  always_comb begin
    control_readback = 16'h0000;
    control_readback[`CTL_TEST_MSB:`CTL_TEST_LSB] = cur.test_code;
    control_readback[`CTL_MANUAL_BIT:`CTL_HALF_BIT] = cur.pending;
  end

  // Read data stands for one cycle after the strobe and is zero otherwise.
  always_comb begin
    next_rdata = 16'h0000;
    if (!sys_rst && cur.defaults_loaded) begin
      if (rd_copper) begin
        next_rdata = cur.np_copper;
      end else if (rd_fiber) begin
        next_rdata = cur.np_fiber;
      end else if (rd_ctrl) begin
        next_rdata = control_readback;
      end
    end
  end

  always_comb begin
    nxt = cur;
    nxt.strap_s1 = negotiation_strap_pattern;
    nxt.strap_s2 = cur.strap_s1;
    nxt.strap_s3 = cur.strap_s2;
    nxt.strap_held = next_strap_held;
    nxt.copper_link_prev = copper_link_up;
    nxt.fiber_link_prev = fiber_link_up;
    nxt.power_down_prev = power_down;
    nxt.np_copper = next_np_copper;
    nxt.np_fiber = next_np_fiber;
    nxt.rdata = next_rdata;
    nxt.test_code = next_test_code;
    nxt.pending = next_pending;
    nxt.active = next_active;
    if (sys_rst) begin
      nxt.defaults_loaded = 1'b0;
      nxt.copper_link_prev = 1'b0;
      nxt.fiber_link_prev = 1'b0;
      nxt.power_down_prev = 1'b0;
    end else begin
      // First cycle after hardware reset release takes the held strap pattern.
      nxt.defaults_loaded = 1'b1;
    end
    nxt.test_mode = decoded_mode;
    nxt.tx_clk_from_rx = jitter_mode;
    nxt.manual_ms = eff_manual;
    nxt.force_master = eff_value;
    nxt.prefer_master = eff_port;
    nxt.adv_full = eff_full;
    nxt.adv_half = eff_half;
  end

  // The whole state moves on every edge; reset is decoded in the next-state logic.
  always_ff @(posedge clk) begin
    cur <= nxt;
  end

  // Every output is a register of the state.
  always_comb begin
    reg_rdata = cur.rdata;
    test_mode = cur.test_mode;
    tx_clk_from_rx = cur.tx_clk_from_rx;
    manual_ms = cur.manual_ms;
    force_master = cur.force_master;
    prefer_master = cur.prefer_master;
    adv_full = cur.adv_full;
    adv_half = cur.adv_half;
  end

endmodule // gig_autoneg_nextpage_ctrl_regs

// >>> gig_autoneg_consts.svh
`ifndef GIG_AUTONEG_CONSTS_SVH
`define GIG_AUTONEG_CONSTS_SVH

// Register numbers within a page, and the page numbers.
`define REG_PARTNER_NEXT_PAGE 5'h08
`define REG_GIGABIT_CONTROL 5'h09
`define PAGE_COPPER 8'h00
`define PAGE_FIBER 8'h01

// Received next page field positions.
`define NP_NEXT_PAGE_BIT 15
`define NP_ACK_BIT 14
`define NP_MESSAGE_BIT 13
`define NP_ACK2_BIT 12
`define NP_TOGGLE_BIT 11
`define NP_FIELD_MSB 10
`define NP_FIELD_LSB 0
`define NP_RESET 16'h0000

// Control register field positions.
`define CTL_TEST_MSB 15
`define CTL_TEST_LSB 13
`define CTL_MANUAL_BIT 12
`define CTL_VALUE_BIT 11
`define CTL_PORT_BIT 10
`define CTL_FULL_BIT 9
`define CTL_HALF_BIT 8
`define CTL_TEST_RESET 3'h0

// Strap pattern positions: pattern is written [3:0].
`define STRAP_FULL_BIT 3
`define STRAP_HALF_BIT 2
`define STRAP_MANUAL_BIT 1
`define STRAP_ROLE_BIT 0

`endif

// >>> gig_autoneg_pkg.sv
package gig_autoneg_pkg;

  typedef enum logic [2:0] {
    TM_NORMAL,
    TM_WAVEFORM,
    TM_JITTER_MASTER,
    TM_JITTER_SLAVE,
    TM_DISTORTION,
    TM_RESERVED
  } test_mode_e;

  typedef struct packed {
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;
    logic [3:0] strap_s3;
    logic [3:0] strap_held;
    logic defaults_loaded;
    logic [15:0] np_copper;
    logic [15:0] np_fiber;
    logic [2:0] test_code;
    logic [4:0] pending;
    logic [4:0] active;
    logic copper_link_prev;
    logic fiber_link_prev;
    logic power_down_prev;
    logic [15:0] rdata;
    test_mode_e test_mode;
    logic tx_clk_from_rx;
    logic manual_ms;
    logic force_master;
    logic prefer_master;
    logic adv_full;
    logic adv_half;
  } state_s;

endpackage

// >>> link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model (
  input wire logic clk,
  output logic [1:0] link_up,
  output logic [1:0] np_valid,
  output logic [1:0][15:0] np_word
);
  initial begin
    link_up = 2'h3;
    np_valid = 2'h0;
    np_word = '0;
  end
  // Sends one received code word; a released word line shows the inverse, not the old value.
  task automatic page(input int f, input logic [15:0] w);
    @(posedge clk);
    np_valid[f] <= 1'b1;
    np_word[f] <= w;
    @(posedge clk);
    np_valid[f] <= 1'b0;
    np_word[f] <= ~w;
  endtask
  task automatic link(input int f, input logic lvl);
    @(posedge clk);
    link_up[f] <= lvl;
  endtask
endmodule // link_partner_model

// >>> gig_autoneg_monitor.sv
`timescale 1ns/1ps
module gig_autoneg_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_page,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic soft_reset,
  input wire logic negotiation_restart,
  input wire logic power_down,
  input wire logic copper_link_up,
  input wire gig_autoneg_pkg::test_mode_e test_mode,
  input wire logic tx_clk_from_rx,
  input wire logic manual_ms,
  input wire logic force_master,
  input wire logic prefer_master,
  input wire logic adv_full,
  input wire logic adv_half
);
  import gig_autoneg_pkg::*;
  logic [1:0] settle;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Strap defaults land a few edges after reset; the deferral check waits for them.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      settle <= 2'h0;
    end else if (settle != 2'h3) begin
      settle <= settle + 2'h1;
    end
  end
  a_jitter_clock: assert property (tx_clk_from_rx == (test_mode inside {TM_JITTER_MASTER, TM_JITTER_SLAVE}))
    else $error("jitter clock source wrong");
  a_restart_clear: assert property (negotiation_restart |=> test_mode == TM_NORMAL) else $error("test mode kept");
  a_test_decode: assert property (reg_write && reg_page == 8'h00 && reg_addr == 5'h09 && reg_wdata[15:13] == 3'h4
    && !negotiation_restart |=> test_mode == TM_DISTORTION) else $error("test decode wrong");
  a_soft_keeps: assert property (soft_reset && !negotiation_restart && !reg_write |=> $stable(test_mode))
    else $error("test mode lost");
  a_value_gated: assert property (force_master |-> manual_ms) else $error("role value not gated");
  a_port_gated: assert property (prefer_master |-> !manual_ms) else $error("port type not gated");
  a_write_deferred: assert property (settle == 2'h3 && !soft_reset && !negotiation_restart && !$fell(power_down)
    && !$fell(copper_link_up) |=> $stable({manual_ms, force_master, prefer_master, adv_full, adv_half}))
    else $error("control applied without event");
  a_hole_zero: assert property (reg_read && reg_page == 8'h01 && reg_addr == 5'h09 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  c_restart: cover property (negotiation_restart);
  c_power_up: cover property ($fell(power_down));
  c_link_loss: cover property ($fell(copper_link_up));
endmodule // gig_autoneg_monitor

bind gig_autoneg_nextpage_ctrl_regs gig_autoneg_monitor u_monitor (.clk, .sys_rst, .reg_page, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .soft_reset, .negotiation_restart, .power_down, .copper_link_up, .test_mode,
  .tx_clk_from_rx, .manual_ms, .force_master, .prefer_master, .adv_full, .adv_half);

// >>> gig_autoneg_nextpage_ctrl_regs_test.sv
`timescale 1ns/1ps
module gig_autoneg_nextpage_ctrl_regs_test;
  import gig_autoneg_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic soft_reset = 1'b0, negotiation_restart = 1'b0, power_down = 1'b0;
  logic [7:0] reg_page = 8'h00;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd, v;
  logic [3:0] strap = 4'hA;
  logic [3:0][15:0] tbl = {16'h0100, 16'h1B00, 16'h1C00, 16'h0F00};
  logic [1:0] link_up, np_valid;
  logic [1:0][15:0] np_word;
  test_mode_e test_mode;
  logic tx_clk_from_rx, manual_ms, force_master, prefer_master, adv_full, adv_half;
  int num_errors = 0, n_compared = 0, cycles = 0;
  always #12.5 clk = ~clk;
  link_partner_model u_partner (.clk(clk), .link_up(link_up), .np_valid(np_valid), .np_word(np_word));
  gig_autoneg_nextpage_ctrl_regs u_dut (.clk, .sys_rst, .reg_page, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .negotiation_strap_pattern(strap), .soft_reset, .negotiation_restart, .power_down,
    .copper_link_up(link_up[0]), .fiber_link_up(link_up[1]), .copper_np_valid(np_valid[0]),
    .copper_np_word(np_word[0]), .fiber_np_valid(np_valid[1]), .fiber_np_word(np_word[1]), .test_mode,
    .tx_clk_from_rx, .manual_ms, .force_master, .prefer_master, .adv_full, .adv_half);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [7:0] p, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= wr;
    reg_read <= !wr;
    reg_page <= p;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
  endtask
  // Apply events: 0 software reset, 1 negotiation restart, 2 power-up, 3 copper link loss.
  task automatic ev(input int k);
    if (k == 3) u_partner.link(0, 1'b0);
    else begin
      @(posedge clk);
      soft_reset <= (k == 0);
      negotiation_restart <= (k == 1);
      power_down <= (k == 2);
    end
    @(posedge clk);
    soft_reset <= 1'b0;
    negotiation_restart <= 1'b0;
    power_down <= 1'b0;
    if (k == 3) u_partner.link(0, 1'b1);
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic ctl(input logic [15:0] w);
    check({11'h0, manual_ms, force_master, prefer_master, adv_full, adv_half},
      {11'h0, w[12], w[12] & w[11], !w[12] & w[10], w[9], w[8]});
  endtask
  initial begin
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      sys_rst <= 1'b1;
      strap <= i ? 4'h5 : 4'hA;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      v = {3'h0, ~strap[1], ~strap[0], ~strap[0], strap[3], strap[2], 8'h00};
      ctl(v);
      acc(0, 8'h00, 5'h09, 16'h0000);
      check(rd, v);
    end
    acc(0, 8'h00, 5'h08, 16'h0000);
    check(rd, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      acc(1, 8'h00, 5'h09, tbl[k]);
      repeat (3) @(posedge clk);
      @(negedge clk);
      ctl(v);
      acc(0, 8'h00, 5'h09, 16'h0000);
      check(rd, tbl[k]);
      ev(k);
      ctl(tbl[k]);
      v = tbl[k];
    end
    for (int c = 0; c < 8; c++) begin
      acc(1, 8'h00, 5'h09, {3'(c), 13'h0100});
      check({13'h0, test_mode}, {13'h0, (c < 5) ? 3'(c) : TM_RESERVED});
      check({15'h0, tx_clk_from_rx}, {15'h0, c == 2 || c == 3});
    end
    acc(1, 8'h00, 5'h09, 16'h6100);
    ev(0);
    check({13'h0, test_mode}, {13'h0, TM_JITTER_SLAVE});
    ev(1);
    check({13'h0, test_mode}, {13'h0, TM_NORMAL});
    ev(0);
    u_partner.page(0, 16'hA5C3);
    u_partner.page(1, 16'h5A3C);
    repeat (4) @(posedge clk);
    acc(0, 8'h00, 5'h08, 16'h0000);
    check(rd, 16'hA5C3);
    acc(0, 8'h01, 5'h08, 16'h0000);
    check(rd, 16'h5A3C);
    acc(1, 8'h01, 5'h09, 16'hFFFF);
    acc(0, 8'h01, 5'h09, 16'h0000);
    check(rd, 16'h0000);
    u_partner.link(0, 1'b0);
    acc(0, 8'h00, 5'h08, 16'h0000);
    check(rd, 16'h0000);
    u_partner.link(1, 1'b0);
    acc(0, 8'h01, 5'h08, 16'h0000);
    check(rd, 16'h0000);
    print_verdict();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      print_verdict();
    end
  end
endmodule // gig_autoneg_nextpage_ctrl_regs_test
